// ---- rtcar_alarm_unit.sv ----
// Purpose: alarm enable, interval select, repeat counter and alarm value slots of the clock
// Assumes: time_i and tick_i come from the timebase on sys_clk_i; tick_i pulses once per half second
// Notes: registers on a plain port, read data one cycle after the read strobe
//
// Contract
// - alarms fire only while alarm_enable is set, which clears itself after an event at count zero without roll-over.
// - the repeat count is the number of further alarms, 255 down to none.
// - interval codes 0000,0011,0100,0101,0110,0111,1000,1001 mean half second, minute, ten minutes, hour, day, week, month, year.
// - a yearly alarm on February 29th fires only once in four years.
// - the pointer decrements after each window access and halts at 00.
// - the pointer routes 00 to minutes/seconds, 01 to weekday/hours, 10 to month/day, 11 to nothing.
// - month tens digit sits at bit 12 and ones digit at bits 11-8.
// - day tens digit sits at bits 5-4 and ones digit at bits 3-0.
// - the month/day value accepts writes only while clock_write_unlock is 1.
// - bits 15-13 and 7-6 of the month/day value read as zero.
`timescale 1ns/10ps
module rtcar_alarm_unit (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [rtcar_pkg::RTCAR_AW-1:0] addr_i,
    input wire logic [rtcar_pkg::RTCAR_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire rtcar_pkg::rtcar_time_s time_i,
    input wire logic tick_i,
    output logic [rtcar_pkg::RTCAR_DW-1:0] rdata_o,
    output logic alarm_event_o,
    output logic alarm_enable_o,
    output logic irq_o
);
    import rtcar_pkg::*;

    rtcar_bus_s bus;
    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    logic alarm_enable;
    logic roll_over;
    logic [3:0] alarm_interval_select;
    logic [1:0] alarm_value_pointer;
    logic [7:0] alarm_repeat_count;
    logic [7:0] alarm_seconds_slot;
    logic [7:0] alarm_minutes_slot;
    logic [7:0] alarm_hours_slot;
    logic [7:0] alarm_weekday_slot;
    logic [7:0] alarm_day_slot;
    logic [7:0] alarm_month_slot;
    logic clock_write_unlock;
    logic [RTCAR_INT_W-1:0] int_status;
    logic [RTCAR_INT_W-1:0] int_mask;
    logic [15:0] rdata;
    logic alarm_event;
    logic irq;

    logic next_alarm_enable;
    logic next_roll_over;
    logic [3:0] next_alarm_interval_select;
    logic [1:0] next_alarm_value_pointer;
    logic [7:0] next_alarm_repeat_count;
    logic [7:0] next_alarm_seconds_slot;
    logic [7:0] next_alarm_minutes_slot;
    logic [7:0] next_alarm_hours_slot;
    logic [7:0] next_alarm_weekday_slot;
    logic [7:0] next_alarm_day_slot;
    logic [7:0] next_alarm_month_slot;
    logic next_clock_write_unlock;
    logic [RTCAR_INT_W-1:0] next_int_status;
    logic [RTCAR_INT_W-1:0] next_int_mask;
    logic [15:0] next_rdata;
    logic next_alarm_event;
    logic next_irq;

    // field selection per interval
    logic use_sec_ones;
    logic use_sec_tens;
    logic use_min_ones;
    logic use_min_tens;
    logic use_hour;
    logic use_wday;
    logic use_day;
    logic use_month;
    logic phase_ok;
    logic valid_code;
    logic [7:0] field_match;
    logic hit;

    always_comb begin
        use_sec_ones = 1'b0;
        use_sec_tens = 1'b0;
        use_min_ones = 1'b0;
        use_min_tens = 1'b0;
        use_hour = 1'b0;
        use_wday = 1'b0;
        use_day = 1'b0;
        use_month = 1'b0;
        phase_ok = 1'b1;
        valid_code = 1'b1;
        case (alarm_interval_select)
            RTCAR_HALF_SEC: begin
                phase_ok = 1'b1;
            end
            RTCAR_ONE_SEC: begin
                phase_ok = !time_i.half;
            end
            RTCAR_TEN_SEC: begin
                phase_ok = !time_i.half;
                use_sec_ones = 1'b1;
            end
            RTCAR_MINUTE: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens} = 2'h3;
            end
            RTCAR_TEN_MIN: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones} = 3'h7;
            end
            RTCAR_HOUR: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones, use_min_tens} = 4'hF;
            end
            RTCAR_DAY: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones, use_min_tens, use_hour} = 5'h1F;
            end
            RTCAR_WEEK: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones, use_min_tens, use_hour, use_wday} = 6'h3F;
            end
            RTCAR_MONTH: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones, use_min_tens, use_hour, use_day} = 6'h3F;
            end
            // feb 29 exists only in leap years, so a full date match limits it
            RTCAR_YEAR: begin
                phase_ok = !time_i.half;
                {use_sec_ones, use_sec_tens, use_min_ones, use_min_tens, use_hour, use_day, use_month} = 7'h7F;
            end
            default: begin
                valid_code = 1'b0;
            end
        endcase
    end

    rtcar_field_match #(.W(4)) u_sec_ones (.now_i(time_i.seconds[3:0]), .alarm_i(alarm_seconds_slot[3:0]),
        .used_i(use_sec_ones), .match_o(field_match[0]));
    rtcar_field_match #(.W(4)) u_sec_tens (.now_i(time_i.seconds[7:4] & RTCAR_SEC_MASK[7:4]),
        .alarm_i(alarm_seconds_slot[7:4] & RTCAR_SEC_MASK[7:4]), .used_i(use_sec_tens), .match_o(field_match[1]));
    rtcar_field_match #(.W(4)) u_min_ones (.now_i(time_i.minutes[3:0]), .alarm_i(alarm_minutes_slot[3:0]),
        .used_i(use_min_ones), .match_o(field_match[2]));
    rtcar_field_match #(.W(4)) u_min_tens (.now_i(time_i.minutes[7:4] & RTCAR_MIN_MASK[7:4]),
        .alarm_i(alarm_minutes_slot[7:4] & RTCAR_MIN_MASK[7:4]), .used_i(use_min_tens), .match_o(field_match[3]));
    rtcar_field_match #(.W(8)) u_hour (.now_i(time_i.hours & RTCAR_HOUR_MASK),
        .alarm_i(alarm_hours_slot & RTCAR_HOUR_MASK), .used_i(use_hour), .match_o(field_match[4]));
    rtcar_field_match #(.W(8)) u_wday (.now_i(time_i.weekday & RTCAR_WDAY_MASK),
        .alarm_i(alarm_weekday_slot & RTCAR_WDAY_MASK), .used_i(use_wday), .match_o(field_match[5]));
    rtcar_field_match #(.W(8)) u_day (.now_i(time_i.day & RTCAR_MTHDAY_MASK[7:0]),
        .alarm_i(alarm_day_slot & RTCAR_MTHDAY_MASK[7:0]), .used_i(use_day), .match_o(field_match[6]));
    rtcar_field_match #(.W(8)) u_month (.now_i(time_i.month & RTCAR_MTHDAY_MASK[15:8]),
        .alarm_i(alarm_month_slot & RTCAR_MTHDAY_MASK[15:8]), .used_i(use_month), .match_o(field_match[7]));

    assign hit = tick_i && alarm_enable && valid_code && phase_ok && (&field_match);

    logic win_access;
    logic [15:0] win_read;
    logic [15:0] mthday_read;
    assign win_access = (bus.wr || bus.rd) && bus.addr == RTCAR_OFS_WINDOW;
    // month digits in the high byte
    // day digits in the low byte
    assign mthday_read = {alarm_month_slot, alarm_day_slot} & RTCAR_MTHDAY_MASK;

    always_comb begin
        unique case (alarm_value_pointer)
            RTCAR_PTR_MIN_SEC: win_read = {alarm_minutes_slot & RTCAR_MIN_MASK, alarm_seconds_slot & RTCAR_SEC_MASK};
            RTCAR_PTR_WD_HOUR: win_read = {alarm_weekday_slot & RTCAR_WDAY_MASK, alarm_hours_slot & RTCAR_HOUR_MASK};
            RTCAR_PTR_MTH_DAY: win_read = mthday_read;
            RTCAR_PTR_NONE: win_read = 16'h0000;
        endcase
    end

    always_comb begin
        next_alarm_enable = alarm_enable;
        next_roll_over = roll_over;
        next_alarm_interval_select = alarm_interval_select;
        next_alarm_value_pointer = alarm_value_pointer;
        next_alarm_repeat_count = alarm_repeat_count;
        next_alarm_seconds_slot = alarm_seconds_slot;
        next_alarm_minutes_slot = alarm_minutes_slot;
        next_alarm_hours_slot = alarm_hours_slot;
        next_alarm_weekday_slot = alarm_weekday_slot;
        next_alarm_day_slot = alarm_day_slot;
        next_alarm_month_slot = alarm_month_slot;
        next_clock_write_unlock = clock_write_unlock;
        next_int_mask = int_mask;
        next_int_status = int_status;
        next_rdata = 16'h0000;
        next_alarm_event = hit;
        if (bus.wr) begin
            unique case (bus.addr)
                RTCAR_OFS_CFG: begin
                    next_alarm_enable = bus.wdata[RTCAR_BIT_ENABLE];
                    next_roll_over = bus.wdata[RTCAR_BIT_ROLL];
                    next_alarm_interval_select = bus.wdata[RTCAR_SEL_LSB +: 4];
                    next_alarm_value_pointer = bus.wdata[RTCAR_PTR_LSB +: 2];
                    next_alarm_repeat_count = bus.wdata[7:0];
                end
                RTCAR_OFS_WINDOW: begin
                    unique case (alarm_value_pointer)
                        RTCAR_PTR_MIN_SEC: {next_alarm_minutes_slot, next_alarm_seconds_slot} = bus.wdata;
                        RTCAR_PTR_WD_HOUR: {next_alarm_weekday_slot, next_alarm_hours_slot} = bus.wdata;
                        RTCAR_PTR_MTH_DAY: begin
                            if (clock_write_unlock) begin
                                {next_alarm_month_slot, next_alarm_day_slot} = bus.wdata & RTCAR_MTHDAY_MASK;
                            end
                        end
                        RTCAR_PTR_NONE: begin
                        end
                    endcase
                end
                RTCAR_OFS_MTHDAY: begin
                    if (clock_write_unlock) begin
                        {next_alarm_month_slot, next_alarm_day_slot} = bus.wdata & RTCAR_MTHDAY_MASK;
                    end
                end
                RTCAR_OFS_CTRL: next_clock_write_unlock = bus.wdata[0];
                RTCAR_OFS_INT_STAT: next_int_status = int_status & ~bus.wdata[RTCAR_INT_W-1:0];
                RTCAR_OFS_INT_MASK: next_int_mask = bus.wdata[RTCAR_INT_W-1:0];
                default: begin
                end
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                RTCAR_OFS_CFG: next_rdata = {alarm_enable, roll_over, alarm_interval_select,
                    alarm_value_pointer, alarm_repeat_count};
                RTCAR_OFS_WINDOW: next_rdata = win_read;
                RTCAR_OFS_MTHDAY: next_rdata = mthday_read;
                RTCAR_OFS_CTRL: next_rdata = {15'h0000, clock_write_unlock};
                RTCAR_OFS_INT_STAT: next_rdata = {14'h0000, int_status};
                RTCAR_OFS_INT_MASK: next_rdata = {14'h0000, int_mask};
                default: next_rdata = 16'h0000;
            endcase
        end
        // step pointer down, halt at 00
        if (win_access && alarm_value_pointer != RTCAR_PTR_MIN_SEC) begin
            next_alarm_value_pointer = alarm_value_pointer - 2'h1;
        end
        if (hit) begin
            // hardware set wins over a same-cycle clear
            next_int_status[RTCAR_INT_EVENT] = 1'b1;
            if (alarm_repeat_count == RTCAR_COUNT_END) begin
                if (roll_over) begin
                    next_alarm_repeat_count = RTCAR_COUNT_WRAP;
                end else begin
                    next_alarm_enable = 1'b0;
                    next_int_status[RTCAR_INT_DONE] = 1'b1;
                end
            end else begin
                // count is alarms still to come
                next_alarm_repeat_count = alarm_repeat_count - 8'h01;
            end
        end
        next_irq = |(next_int_status & next_int_mask);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            {alarm_enable, roll_over, alarm_interval_select, alarm_value_pointer, alarm_repeat_count} <= RTCAR_CFG_RST;
            alarm_seconds_slot <= RTCAR_SLOT_RST;
            alarm_minutes_slot <= RTCAR_SLOT_RST;
            alarm_hours_slot <= RTCAR_SLOT_RST;
            alarm_weekday_slot <= RTCAR_SLOT_RST;
            alarm_day_slot <= RTCAR_SLOT_RST;
            alarm_month_slot <= RTCAR_SLOT_RST;
            clock_write_unlock <= 1'b0;
            int_status <= '0;
            int_mask <= '0;
            rdata <= 16'h0000;
            alarm_event <= 1'b0;
            irq <= 1'b0;
        end else if (ce_i) begin
            alarm_enable <= next_alarm_enable;
            roll_over <= next_roll_over;
            alarm_interval_select <= next_alarm_interval_select;
            alarm_value_pointer <= next_alarm_value_pointer;
            alarm_repeat_count <= next_alarm_repeat_count;
            alarm_seconds_slot <= next_alarm_seconds_slot;
            alarm_minutes_slot <= next_alarm_minutes_slot;
            alarm_hours_slot <= next_alarm_hours_slot;
            alarm_weekday_slot <= next_alarm_weekday_slot;
            alarm_day_slot <= next_alarm_day_slot;
            alarm_month_slot <= next_alarm_month_slot;
            clock_write_unlock <= next_clock_write_unlock;
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            rdata <= next_rdata;
            alarm_event <= next_alarm_event;
            irq <= next_irq;
        end
    end

    assign rdata_o = rdata;
    assign alarm_event_o = alarm_event;
    assign alarm_enable_o = alarm_enable;
    assign irq_o = irq;
endmodule : rtcar_alarm_unit

// ---- rtcar_pkg.sv ----
// Purpose: shared constants and types of the alarm repeat unit, plus its field comparator
// Assumes: time fields arrive in BCD from logic on sys_clk_i
// Notes: the comparator is purely combinational
`timescale 1ns/10ps
package rtcar_pkg;
    localparam int RTCAR_AW = 3;
    localparam int RTCAR_DW = 16;
    // register word offsets
    localparam logic [2:0] RTCAR_OFS_CFG = 3'h0;
    localparam logic [2:0] RTCAR_OFS_WINDOW = 3'h1;
    localparam logic [2:0] RTCAR_OFS_MTHDAY = 3'h2;
    localparam logic [2:0] RTCAR_OFS_CTRL = 3'h3;
    localparam logic [2:0] RTCAR_OFS_INT_STAT = 3'h4;
    localparam logic [2:0] RTCAR_OFS_INT_MASK = 3'h5;
    // config/repeat field positions
    localparam int RTCAR_BIT_ENABLE = 15;
    localparam int RTCAR_BIT_ROLL = 14;
    localparam int RTCAR_SEL_LSB = 10;
    localparam int RTCAR_PTR_LSB = 8;
    // readable bits of each slot
    localparam logic [15:0] RTCAR_MTHDAY_MASK = 16'h1F3F;
    localparam logic [7:0] RTCAR_SEC_MASK = 8'h7F;
    localparam logic [7:0] RTCAR_MIN_MASK = 8'h7F;
    localparam logic [7:0] RTCAR_HOUR_MASK = 8'h3F;
    localparam logic [7:0] RTCAR_WDAY_MASK = 8'h07;
    // reset values, and the repeat count end and wrap values
    localparam logic [15:0] RTCAR_CFG_RST = 16'h0000;
    localparam logic [7:0] RTCAR_SLOT_RST = 8'h00;
    localparam logic [7:0] RTCAR_COUNT_END = 8'h00;
    localparam logic [7:0] RTCAR_COUNT_WRAP = 8'hFF;
    // interrupt status bits
    localparam int RTCAR_INT_W = 2;
    localparam int RTCAR_INT_EVENT = 0;
    localparam int RTCAR_INT_DONE = 1;

    typedef enum logic [3:0] {
        RTCAR_HALF_SEC = 4'b0000,
        RTCAR_ONE_SEC = 4'b0001,
        RTCAR_TEN_SEC = 4'b0010,
        RTCAR_MINUTE = 4'b0011,
        RTCAR_TEN_MIN = 4'b0100,
        RTCAR_HOUR = 4'b0101,
        RTCAR_DAY = 4'b0110,
        RTCAR_WEEK = 4'b0111,
        RTCAR_MONTH = 4'b1000,
        RTCAR_YEAR = 4'b1001
    } rtcar_interval_e;

    typedef enum logic [1:0] {
        RTCAR_PTR_MIN_SEC = 2'b00,
        RTCAR_PTR_WD_HOUR = 2'b01,
        RTCAR_PTR_MTH_DAY = 2'b10,
        RTCAR_PTR_NONE = 2'b11
    } rtcar_ptr_e;

    typedef struct packed {
        logic half;
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] weekday;
        logic [7:0] day;
        logic [7:0] month;
    } rtcar_time_s;

    typedef struct packed {
        logic [RTCAR_AW-1:0] addr;
        logic [RTCAR_DW-1:0] wdata;
        logic wr;
        logic rd;
    } rtcar_bus_s;
endpackage : rtcar_pkg

module rtcar_field_match #(
    parameter int W = 8
) (
    input wire logic [W-1:0] now_i,
    input wire logic [W-1:0] alarm_i,
    input wire logic used_i,
    output logic match_o
);
    // a bcd slot is one byte at most, so wider fields have no meaning
    if (W < 1 || W > 8) begin : g_bad_width
        $error("field width out of range");
    end
    // a field the interval does not look at always matches
    assign match_o = !used_i || (now_i == alarm_i);
endmodule : rtcar_field_match

// ---- rtcar_alarm_unit_assertions.sv ----
// Purpose: port-level checks of the alarm repeat unit
// Assumes: one clock, synchronous active-high reset
// Notes: the interval code is shadowed from config writes, since it is not visible at the ports
`timescale 1ns/10ps
module rtcar_alarm_unit_assertions
    import rtcar_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    input wire logic [rtcar_pkg::RTCAR_AW-1:0] addr_i,
    input wire logic [rtcar_pkg::RTCAR_DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire rtcar_pkg::rtcar_time_s time_i,
    input wire logic tick_i,
    input wire logic [rtcar_pkg::RTCAR_DW-1:0] rdata_o,
    input wire logic alarm_event_o,
    input wire logic alarm_enable_o,
    input wire logic irq_o
);
    logic [3:0] interval_sel;
    logic [3:0] next_interval_sel;
    logic cfg_wr;

    assign cfg_wr = ce_i && wr_i && addr_i == RTCAR_OFS_CFG;

    always_comb begin
        next_interval_sel = interval_sel;
        if (cfg_wr) begin
            next_interval_sel = wdata_i[RTCAR_SEL_LSB+:4];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            interval_sel <= 4'h0;
        end else begin
            interval_sel <= next_interval_sel;
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    ev_needs_enable_a: assert property (
        alarm_event_o && $past(ce_i) |-> $past(alarm_enable_o)) else $error("event while disabled");
    ev_needs_tick_a: assert property (
        alarm_event_o && $past(ce_i) |-> $past(tick_i)) else $error("event without tick");
    en_rise_cause_a: assert property (
        $rose(alarm_enable_o) |-> $past(cfg_wr && wdata_i[RTCAR_BIT_ENABLE])) else $error("enable rose alone");
    en_fall_cause_a: assert property (
        $fell(alarm_enable_o) && !$past(sys_rst_i) |-> alarm_event_o || $past(cfg_wr))
        else $error("enable fell alone");
    reserved_silent_a: assert property (
        alarm_event_o && $past(ce_i) |-> $past(interval_sel) <= 4'h9) else $error("reserved code fired");
    half_gate_a: assert property (
        alarm_event_o && $past(ce_i) && $past(interval_sel) != 4'h0 |-> !$past(time_i.half))
        else $error("fired on half second");
    mthday_zero_a: assert property (
        $past(rd_i && ce_i && addr_i == RTCAR_OFS_MTHDAY) && !$past(sys_rst_i)
        |-> (rdata_o & ~RTCAR_MTHDAY_MASK) == 16'h0000) else $error("unimplemented bits set");
    unmapped_zero_a: assert property (
        $past(rd_i && ce_i && addr_i > RTCAR_OFS_INT_MASK) && !$past(sys_rst_i) |-> rdata_o == 16'h0000)
        else $error("unmapped read not zero");
    irq_rise_cause_a: assert property (
        $rose(irq_o) |-> alarm_event_o || $past(ce_i && wr_i && addr_i == RTCAR_OFS_INT_MASK))
        else $error("irq rose alone");
    freeze_a: assert property (
        !ce_i |=> $stable(alarm_enable_o) && $stable(irq_o)) else $error("state moved while frozen");

    event_seen_c: cover property (alarm_event_o);
    auto_clear_c: cover property ($fell(alarm_enable_o) && alarm_event_o);
    irq_seen_c: cover property ($rose(irq_o));
endmodule : rtcar_alarm_unit_assertions

bind rtcar_alarm_unit rtcar_alarm_unit_assertions i_chk (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .time_i(time_i),
    .tick_i(tick_i), .rdata_o(rdata_o), .alarm_event_o(alarm_event_o), .alarm_enable_o(alarm_enable_o),
    .irq_o(irq_o));

// ---- rtc_alarm_repeat_unit_tb.sv ----
// Purpose: directed register and alarm tests of the alarm repeat unit
// Assumes: read data one cycle after the read strobe
// Notes: every access leaves one idle cycle, so no strobe is driven twice in one step
`timescale 1ns/10ps
module rtc_alarm_repeat_unit_tb;
    import rtcar_pkg::*;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic [RTCAR_AW-1:0] addr_i = '0;
    logic [RTCAR_DW-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    rtcar_time_s time_i = '0;
    logic tick_i = 1'b0;
    logic [RTCAR_DW-1:0] rdata_o;
    logic alarm_event_o;
    logic alarm_enable_o;
    logic irq_o;
    int miscompares = 0;
    int n_compared = 0;

    rtcar_alarm_unit i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .time_i(time_i), .tick_i(tick_i), .rdata_o(rdata_o),
        .alarm_event_o(alarm_event_o), .alarm_enable_o(alarm_enable_o), .irq_o(irq_o));

    initial begin
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string msg);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp, msg);
    endtask : rd

    // one tick with the given time; the event must show in the following cycle
    task automatic tick(input rtcar_time_s t, input logic exp, input string msg);
        @(posedge sys_clk_i);
        time_i <= t;
        tick_i <= 1'b1;
        @(posedge sys_clk_i);
        tick_i <= 1'b0;
        #1;
        check({15'h0000, alarm_event_o}, {15'h0000, exp}, msg);
    endtask : tick

    // full match of the stored alarm, with the field of one level disturbed
    function automatic rtcar_time_s mk(input int lvl);
        rtcar_time_s t;
        t = '{half: 1'b0, seconds: 8'h59, minutes: 8'h45, hours: 8'h23, weekday: 8'h03, day: 8'h15,
            month: 8'h07};
        case (lvl)
            1: t.half = 1'b1;
            2: t.seconds = 8'h58;
            3: t.seconds = 8'h49;
            4: t.minutes = 8'h44;
            5: t.minutes = 8'h35;
            6: t.hours = 8'h22;
            7: t.weekday = 8'h02;
            8: t.day = 8'h14;
            9: t.month = 8'h06;
            default: t.half = 1'b0;
        endcase
        return t;
    endfunction : mk

    task automatic finish_test;
        $display("compared %0d, miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a), 16'h0000, "reset value");
        end
        wr(RTCAR_OFS_CFG, 16'h8A05);
        rd(RTCAR_OFS_CFG, 16'h8A05, "config readback");
        check({15'h0000, alarm_enable_o}, 16'h0001, "enable out");
        wr(RTCAR_OFS_CFG, 16'h0200);
        wr(RTCAR_OFS_MTHDAY, 16'h1234);
        rd(RTCAR_OFS_MTHDAY, 16'h0000, "locked write");
        wr(RTCAR_OFS_CTRL, 16'h0001);
        wr(RTCAR_OFS_MTHDAY, 16'hFFFF);
        rd(RTCAR_OFS_MTHDAY, 16'h1F3F, "digit fields");
        wr(RTCAR_OFS_WINDOW, 16'h0715);
        wr(RTCAR_OFS_WINDOW, 16'h0323);
        wr(RTCAR_OFS_WINDOW, 16'h4559);
        rd(RTCAR_OFS_CFG, 16'h0000, "pointer halts");
        rd(RTCAR_OFS_MTHDAY, 16'h0715, "month day slot");
        rd(RTCAR_OFS_WINDOW, 16'h4559, "min sec slot");
        wr(RTCAR_OFS_CFG, 16'h0100);
        rd(RTCAR_OFS_WINDOW, 16'h0323, "weekday hour slot");
        rd(RTCAR_OFS_CFG, 16'h0000, "pointer step");
        wr(RTCAR_OFS_CFG, 16'h0300);
        rd(RTCAR_OFS_WINDOW, 16'h0000, "empty slot");
        rd(RTCAR_OFS_CFG, 16'h0200, "pointer from 11");
        wr(RTCAR_OFS_CTRL, 16'h0000);
        wr(RTCAR_OFS_WINDOW, 16'h0101);
        rd(RTCAR_OFS_MTHDAY, 16'h0715, "locked window");
        wr(3'h7, 16'hFFFF);
        rd(3'h7, 16'h0000, "unmapped");
        $display("register tests done");
        // reserved codes are driven on purpose: they must never fire
        for (int k = 0; k < 16; k++) begin
            wr(RTCAR_OFS_CFG, 16'hC000 | (16'(k) << RTCAR_SEL_LSB));
            for (int l = 0; l < 10; l++) begin
                tick(mk(l), k <= 9 && !(l >= 1 && l <= k && !(l == 7 && k >= 8)), "interval");
            end
        end
        // leap-day alarm needs the full date
        wr(RTCAR_OFS_CTRL, 16'h0001);
        wr(RTCAR_OFS_MTHDAY, 16'h0229);
        wr(RTCAR_OFS_CFG, 16'hE400);
        tick('{1'b0, 8'h59, 8'h45, 8'h23, 8'h03, 8'h29, 8'h02}, 1'b1, "leap day");
        tick('{1'b0, 8'h59, 8'h45, 8'h23, 8'h03, 8'h29, 8'h03}, 1'b0, "other month");
        // a half-second alarm that would fire if the clock enable did not freeze it
        wr(RTCAR_OFS_CFG, 16'hC000);
        @(posedge sys_clk_i);
        ce_i <= 1'b0;
        tick(mk(0), 1'b0, "frozen tick");
        @(posedge sys_clk_i);
        ce_i <= 1'b1;
        $display("interval tests done");
        wr(RTCAR_OFS_INT_STAT, 16'h0003);
        wr(RTCAR_OFS_CFG, 16'h8002);
        tick(mk(0), 1'b1, "repeat 2");
        tick(mk(0), 1'b1, "repeat 1");
        rd(RTCAR_OFS_CFG, 16'h8000, "count down");
        tick(mk(0), 1'b1, "last alarm");
        check({15'h0000, alarm_enable_o}, 16'h0000, "auto disable");
        rd(RTCAR_OFS_CFG, 16'h0000, "count halts");
        tick(mk(0), 1'b0, "after disable");
        rd(RTCAR_OFS_INT_STAT, 16'h0003, "status");
        check({15'h0000, irq_o}, 16'h0000, "masked irq");
        wr(RTCAR_OFS_INT_MASK, 16'h0001);
        rd(RTCAR_OFS_INT_MASK, 16'h0001, "mask");
        check({15'h0000, irq_o}, 16'h0001, "irq raised");
        wr(RTCAR_OFS_INT_STAT, 16'h0001);
        rd(RTCAR_OFS_INT_STAT, 16'h0002, "w1c");
        check({15'h0000, irq_o}, 16'h0000, "irq cleared");
        wr(RTCAR_OFS_CFG, 16'hC000);
        tick(mk(0), 1'b1, "roll alarm");
        rd(RTCAR_OFS_CFG, 16'hC0FF, "wrap to FF");
        check({15'h0000, alarm_enable_o}, 16'h0001, "enable kept");
        $display("repeat tests done");
        finish_test();
    end
endmodule : rtc_alarm_repeat_unit_tb
